//--- hdl/ctr_pkg.sv
// Purpose: shared constants and types for the cache tag and replacement block
// Assumes: one core clock, 32-bit physical and virtual addresses
// Notes: four ways of 64 sets of 16-byte lines
package ctr_pkg;
	localparam int NWAYS = 4;
	localparam int WAYW = 2;
	localparam int NSETS = 64;
	localparam int IDXW = 6;
	localparam int NWORDS = 4;
	localparam int TAGW = 22;
	localparam int TAG_LSB = 10;
	localparam int IDX_LSB = 4;
	localparam int WORD_LSB = 2;
	localparam int CAP_BYTES = NWAYS * NSETS * NWORDS * 4;
	localparam int MAX_CAP_BYTES = 16384;
	localparam logic [2:0] SEG_UNC = 3'h5;
	localparam logic [3:0] VLD_ALL = 4'hf;
	localparam logic [1:0] BEAT_FIRST = 2'h0;
	localparam logic [1:0] BEAT_LAST = 2'h3;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_TAG = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	// field positions and reset values
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int CTRL_EN_BIT = 0;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_WAY_LSB = 4;
	localparam int CMD_IDX_LSB = 8;
	localparam int TR_AGE_BIT = 0;
	localparam int TR_LOCK_BIT = 1;
	localparam int TR_VLD_LSB = 4;
	localparam int TR_TAG_LSB = 10;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WBUF_BIT = 1;
	localparam int ST_MPEND_BIT = 2;
	localparam int ST_VFOUND_BIT = 3;
	localparam int ST_VWAY_LSB = 4;
	typedef enum logic [1:0] {OP_INV, OP_LOCK, OP_UNLOCK, OP_STORE} ctr_op_t;
	typedef enum logic [1:0] {K_FETCH, K_LOAD, K_STORE, K_SYNC} ctr_kind_t;
	typedef enum logic [1:0] {S_IDLE, S_RD_REQ, S_RD_BEAT, S_SYNC} ctr_state_t;
endpackage

//--- hdl/ctr_victim_sel.sv
// Purpose: picks the way that a line fill replaces
// Assumes: per-way state of one indexed set
// Notes: purely combinational
`timescale 1ns/1ps
module ctr_victim_sel
	import ctr_pkg::*;
(
	// per-way state of the set
	input wire logic [NWAYS-1:0] empty_i,
	input wire logic [NWAYS-1:0] lock_i,
	input wire logic [NWAYS-1:0] age_i,
	// choice
	output logic found_o,
	output logic [WAYW-1:0] way_o
);
	logic [NWAYS-1:0] cand;
	logic [NWAYS-1:0] old;

	always_comb begin
		cand = ~lock_i;
		old = cand & ~age_i;
		found_o = 1'b0;
		way_o = '0;
		if (|empty_i) begin
			found_o = 1'b1;
			for (int w = NWAYS - 1; w >= 0; w--) begin
				if (empty_i[w]) begin
					way_o = WAYW'(w);
				end
			end
		end else if (|old) begin
			found_o = 1'b1;
			for (int w = NWAYS - 1; w >= 0; w--) begin
				if (old[w]) begin
					way_o = WAYW'(w);
				end
			end
		end else if (|cand) begin
			found_o = 1'b1;
			for (int w = NWAYS - 1; w >= 0; w--) begin
				if (cand[w]) begin
					way_o = WAYW'(w);
				end
			end
		end
	end
endmodule

//--- hdl/ctr_cache_ctrl.sv
// Purpose: write-through cache tag, data and replacement control
// Assumes: pipeline and bus unit on mclk_i, maintenance over apb
// Notes: arrays are flip-flops without reset
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ctr_cache_ctrl
	import ctr_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// pipeline requests
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [1:0] req_kind_i,
	input wire logic [31:0] req_va_i,
	input wire logic [31:0] req_pa_i,
	input wire logic req_cached_i,
	input wire logic [3:0] req_be_i,
	input wire logic [31:0] req_wdata_i,
	output logic rsp_valid_o,
	output logic [31:0] rsp_data_o,
	// bus reads
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [31:0] rd_addr_o,
	output logic rd_burst_o,
	input wire logic beat_valid_i,
	input wire logic [31:0] beat_data_i,
	// bus writes
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic [31:0] wr_addr_o,
	output logic [3:0] wr_be_o,
	output logic [31:0] wr_data_o
);
	ctr_state_t state_q;
	logic ctrl_en_q;
	logic [31:0] cmd_q;
	logic [31:0] tagreg_q;
	logic mpend_q;
	logic [31:0] prdata_q;
	logic [31:0] rq_pa_q;
	logic [IDXW-1:0] rq_idx_q;
	logic rq_burst_q;
	logic rq_fill_q;
	logic [WAYW-1:0] rq_way_q;
	logic [1:0] beat_q;
	logic [31:0] fb_q [NWORDS];
	logic wbuf_v_q;
	logic [31:0] wbuf_addr_q;
	logic [31:0] wbuf_data_q;
	logic [3:0] wbuf_be_q;
	logic rsp_v_q;
	logic [31:0] rsp_d_q;
	logic vfound_q;
	logic [WAYW-1:0] vway_q;

	logic [IDXW-1:0] req_idx;
	logic [1:0] req_word;
	logic [TAGW-1:0] ptag;
	logic [IDXW-1:0] port_idx;
	logic [TAGW-1:0] way_tag [NWAYS];
	logic [NWORDS-1:0] way_vld [NWAYS];
	logic [31:0] way_word [NWAYS];
	logic [NWAYS-1:0] way_lock;
	logic [NWAYS-1:0] way_age;
	logic [NWAYS-1:0] way_empty;
	logic [NWAYS-1:0] hit;
	logic [NWAYS-1:0] tmatch;
	logic unc;
	logic acc;
	logic is_store;
	logic is_rd;
	logic is_sync;
	logic hit_any;
	logic [31:0] hit_data;
	logic [31:0] merged;
	logic [WAYW-1:0] tm_way;
	logic vic_found;
	logic [WAYW-1:0] vic_way;
	logic fill_ok;
	logic [WAYW-1:0] fill_way;
	logic st_hit_go;
	logic rd_miss;
	logic beat_go;
	logic beat_end;
	logic fill_go;
	logic [1:0] beat_word;
	logic [31:0] fill_line [NWORDS];
	logic [NWAYS-1:0] aged;
	logic [NWAYS-1:0] new_age;
	logic maint_go;
	ctr_op_t mt_op;
	logic [WAYW-1:0] mt_way;
	logic [IDXW-1:0] mt_idx;
	logic apb_wr;
	logic mapped;
	logic [31:0] stat_w;

	assign req_idx = req_va_i[IDX_LSB +: IDXW];
	assign req_word = req_va_i[WORD_LSB +: 2];
	assign ptag = req_pa_i[31:TAG_LSB];
	assign port_idx = (state_q == S_IDLE) ? req_idx : rq_idx_q;
	assign is_store = req_kind_i == K_STORE;
	assign is_rd = (req_kind_i == K_FETCH) || (req_kind_i == K_LOAD);
	assign is_sync = req_kind_i == K_SYNC;
	assign unc = !ctrl_en_q || !req_cached_i || (req_va_i[31:29] == SEG_UNC);
	assign req_ready_o = (state_q == S_IDLE) && !mpend_q && !(is_store && wbuf_v_q);
	assign acc = req_valid_i && req_ready_o;

	for (genvar w = 0; w < NWAYS; w++) begin : g_way
		logic [TAGW-1:0] tag_q [NSETS];
		logic [NWORDS-1:0] vld_q [NSETS];
		logic [NSETS-1:0] lock_q;
		logic [NSETS-1:0] age_q;
		logic [31:0] dat_q [NSETS][NWORDS];
		assign way_tag[w] = tag_q[port_idx];
		assign way_vld[w] = vld_q[port_idx];
		assign way_lock[w] = lock_q[port_idx];
		assign way_age[w] = age_q[port_idx];
		assign way_word[w] = dat_q[port_idx][req_word];
		assign way_empty[w] = vld_q[port_idx] == '0;
		assign tmatch[w] = (tag_q[port_idx] == ptag) && (vld_q[port_idx] != '0);
		assign hit[w] = (tag_q[port_idx] == ptag) && vld_q[port_idx][req_word];
		always_ff @(posedge mclk_i) begin
			if (maint_go && mt_way == WAYW'(w)) begin
				unique case (mt_op)
					OP_INV: begin
						vld_q[mt_idx] <= '0;
					end
					OP_LOCK: begin
						lock_q[mt_idx] <= 1'b1;
					end
					OP_UNLOCK: begin
						lock_q[mt_idx] <= 1'b0;
					end
					OP_STORE: begin
						tag_q[mt_idx] <= tagreg_q[TR_TAG_LSB +: TAGW];
						vld_q[mt_idx] <= tagreg_q[TR_VLD_LSB +: NWORDS];
						lock_q[mt_idx] <= tagreg_q[TR_LOCK_BIT];
						age_q[mt_idx] <= tagreg_q[TR_AGE_BIT];
					end
				endcase
			end
			if (fill_go) begin
				age_q[rq_idx_q] <= new_age[w];
				if (rq_way_q == WAYW'(w)) begin
					tag_q[rq_idx_q] <= rq_pa_q[31:TAG_LSB];
					vld_q[rq_idx_q] <= VLD_ALL;
					for (int j = 0; j < NWORDS; j++) begin
						dat_q[rq_idx_q][j] <= fill_line[j];
					end
				end
			end
			if (st_hit_go && hit[w]) begin
				dat_q[req_idx][req_word] <= merged;
			end
		end
	end

	always_comb begin
		hit_data = '0;
		tm_way = '0;
		for (int w = 0; w < NWAYS; w++) begin
			if (hit[w]) begin
				hit_data = hit_data | way_word[w];
			end
			if (tmatch[w]) begin
				tm_way = WAYW'(w);
			end
		end
	end
	assign hit_any = (|hit) && !unc;

	for (genvar b = 0; b < 4; b++) begin : g_byte
		assign merged[8*b +: 8] = req_be_i[b] ? req_wdata_i[8*b +: 8] : hit_data[8*b +: 8];
	end

	ctr_victim_sel u_victim (
		.empty_i(way_empty),
		.lock_i(way_lock),
		.age_i(way_age),
		.found_o(vic_found),
		.way_o(vic_way)
	);

	// partial line refills into its own way
	assign fill_ok = (|tmatch) || vic_found;
	assign fill_way = (|tmatch) ? tm_way : vic_way;
	assign st_hit_go = acc && is_store && hit_any;
	assign rd_miss = acc && is_rd && !hit_any;
	assign beat_go = (state_q == S_RD_BEAT) && beat_valid_i;
	assign beat_word = 2'(rq_pa_q[WORD_LSB +: 2] + beat_q);
	assign beat_end = beat_go && (!rq_burst_q || beat_q == BEAT_LAST);
	assign fill_go = beat_end && rq_fill_q;
	assign maint_go = mpend_q && (state_q == S_IDLE);
	assign mt_op = ctr_op_t'(cmd_q[CMD_OP_LSB +: 2]);
	assign mt_way = cmd_q[CMD_WAY_LSB +: WAYW];
	assign mt_idx = cmd_q[CMD_IDX_LSB +: IDXW];

	always_comb begin
		for (int j = 0; j < NWORDS; j++) begin
			fill_line[j] = (beat_word == 2'(j)) ? beat_data_i : fb_q[j];
		end
	end

	// age set, wrap when unlocked full
	always_comb begin
		aged = way_age | (NWAYS'(1) << rq_way_q);
		// locked ways refill only when empty or on a tag match, so they count as aged
		new_age = (&(aged | way_lock)) ? (NWAYS'(1) << rq_way_q) : aged;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (rd_miss) begin
						state_q <= S_RD_REQ;
					end else if (acc && is_sync) begin
						state_q <= S_SYNC;
					end
				end
				S_RD_REQ: begin
					if (rd_valid_o && rd_ready_i) begin
						state_q <= S_RD_BEAT;
					end
				end
				S_RD_BEAT: begin
					if (beat_end) begin
						state_q <= S_IDLE;
					end
				end
				S_SYNC: begin
					if (!wbuf_v_q) begin
						state_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rq_pa_q <= '0;
			rq_idx_q <= '0;
			rq_burst_q <= 1'b0;
			rq_fill_q <= 1'b0;
			rq_way_q <= '0;
			vfound_q <= 1'b0;
			vway_q <= '0;
		end else if (rd_miss) begin
			rq_pa_q <= req_pa_i;
			rq_idx_q <= req_idx;
			rq_burst_q <= !unc;
			rq_fill_q <= !unc && fill_ok;
			rq_way_q <= fill_way;
			vfound_q <= vic_found;
			vway_q <= vic_way;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			beat_q <= '0;
		end else if (rd_valid_o && rd_ready_i) begin
			beat_q <= '0;
		end else if (beat_go) begin
			beat_q <= beat_q + 2'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (beat_go) begin
			fb_q[beat_word] <= beat_data_i;
		end
	end

	assign rd_valid_o = (state_q == S_RD_REQ) && !wbuf_v_q;
	assign rd_addr_o = {rq_pa_q[31:WORD_LSB], 2'h0};
	assign rd_burst_o = rq_burst_q;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wbuf_v_q <= 1'b0;
			wbuf_addr_q <= '0;
			wbuf_data_q <= '0;
			wbuf_be_q <= '0;
		end else if (acc && is_store) begin
			wbuf_v_q <= 1'b1;
			wbuf_addr_q <= req_pa_i;
			wbuf_data_q <= req_wdata_i;
			wbuf_be_q <= req_be_i;
		end else if (wr_valid_o && wr_ready_i) begin
			wbuf_v_q <= 1'b0;
		end
	end
	assign wr_valid_o = wbuf_v_q;
	assign wr_addr_o = wbuf_addr_q;
	assign wr_data_o = wbuf_data_q;
	assign wr_be_o = wbuf_be_q;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rsp_v_q <= 1'b0;
			rsp_d_q <= '0;
		end else begin
			rsp_v_q <= (acc && (is_store || (is_rd && hit_any)))
				|| (beat_go && beat_q == BEAT_FIRST)
				|| (state_q == S_SYNC && !wbuf_v_q);
			if (acc && is_rd && hit_any) begin
				rsp_d_q <= hit_data;
			end else if (beat_go && beat_q == BEAT_FIRST) begin
				rsp_d_q <= beat_data_i;
			end
		end
	end
	assign rsp_valid_o = rsp_v_q;
	assign rsp_data_o = rsp_d_q;

	// apb slave
	assign mapped = (paddr_i == OFS_CTRL) || (paddr_i == OFS_CMD)
		|| (paddr_i == OFS_TAG) || (paddr_i == OFS_STAT);
	assign pready_o = !(psel_i && pwrite_i && paddr_i == OFS_CMD && mpend_q);
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign apb_wr = psel_i && penable_i && pready_o && pwrite_i && mapped;
	assign prdata_o = prdata_q;

	always_comb begin
		stat_w = '0;
		stat_w[ST_BUSY_BIT] = state_q != S_IDLE;
		stat_w[ST_WBUF_BIT] = wbuf_v_q;
		stat_w[ST_MPEND_BIT] = mpend_q;
		stat_w[ST_VFOUND_BIT] = vfound_q;
		stat_w[ST_VWAY_LSB +: WAYW] = vway_q;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_en_q <= CTRL_EN_RST;
			cmd_q <= '0;
			tagreg_q <= '0;
			mpend_q <= 1'b0;
		end else begin
			if (apb_wr && paddr_i == OFS_CTRL) begin
				ctrl_en_q <= pwdata_i[CTRL_EN_BIT];
			end
			if (apb_wr && paddr_i == OFS_TAG) begin
				tagreg_q <= pwdata_i;
			end
			if (apb_wr && paddr_i == OFS_CMD) begin
				cmd_q <= pwdata_i;
				mpend_q <= 1'b1;
			end else if (maint_go) begin
				mpend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_q <= '0;
		end else if (psel_i && !penable_i) begin
			unique case (paddr_i)
				OFS_CTRL: prdata_q <= {31'h0, ctrl_en_q};
				OFS_CMD: prdata_q <= cmd_q;
				OFS_TAG: prdata_q <= tagreg_q;
				OFS_STAT: prdata_q <= stat_w;
				default: prdata_q <= '0;
			endcase
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	property p_hit_rsp;
		acc && is_rd && hit_any |=> rsp_valid_o && rsp_data_o == $past(hit_data);
	endproperty
	a_hit_rsp: assert property (p_hit_rsp)
		else $error("load hit not answered next cycle");
	property p_unc_rd;
		acc && is_rd && unc |=> state_q == S_RD_REQ && !rd_burst_o && !rq_fill_q;
	endproperty
	a_unc_rd: assert property (p_unc_rd)
		else $error("uncached load touched the cache");
	property p_seg;
		acc && is_store && req_va_i[31:29] == SEG_UNC |-> !st_hit_go;
	endproperty
	a_seg: assert property (p_seg)
		else $error("uncached segment store updated the cache");
	property p_miss;
		acc && is_rd && !unc && !hit_any |=> state_q == S_RD_REQ && rd_burst_o;
	endproperty
	a_miss: assert property (p_miss)
		else $error("cacheable miss did not start a burst");
	property p_wt;
		acc && is_store |=> wr_valid_o && wr_addr_o == $past(req_pa_i);
	endproperty
	a_wt: assert property (p_wt)
		else $error("store not forwarded to memory");
	property p_crit;
		beat_go && beat_q == BEAT_FIRST |=> rsp_valid_o && rsp_data_o == $past(beat_data_i);
	endproperty
	a_crit: assert property (p_crit)
		else $error("critical word not returned on first beat");
	property p_sync;
		rsp_valid_o && $past(state_q) == S_SYNC |-> $past(wbuf_v_q) == 1'b0;
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync finished with writes pending");
	property p_empty;
		vic_found && way_empty[0] |-> vic_way == '0;
	endproperty
	a_empty: assert property (p_empty)
		else $error("empty way 0 not chosen");
	property p_lock;
		vic_found && !(|way_empty) |-> !way_lock[vic_way];
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked way chosen as victim");
	property p_age;
		vic_found && !(|way_empty) && |(~way_lock & ~way_age) |-> !way_age[vic_way];
	endproperty
	a_age: assert property (p_age)
		else $error("victim not least recently filled");

	c_hit: cover property (acc && is_rd && hit_any);
	c_fill: cover property (fill_go);
	c_sync: cover property (state_q == S_SYNC && !wbuf_v_q);
	c_locked: cover property (rd_miss && !unc && !fill_ok);
endmodule

//--- tb/ctr_bus_model.sv
// Purpose: memory behind the bus unit, answers refills and stores
// Assumes: handshakes sampled at rising edges
// Notes: slow_i halves the pace of every answer
`timescale 1ns/1ps
module ctr_bus_model (
	// clock and control
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	// reads
	input wire logic rd_valid_i,
	output logic rd_ready_o,
	input wire logic [31:0] rd_addr_i,
	input wire logic rd_burst_i,
	output logic beat_valid_o,
	output logic [31:0] beat_data_o,
	// writes
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [31:0] wr_addr_i,
	input wire logic [3:0] wr_be_i,
	input wire logic [31:0] wr_data_i
);
	logic [31:0] mem [int unsigned];
	logic [31:0] base_q;
	logic [31:0] tmp;
	logic [2:0] left_q;
	logic [1:0] wofs_q;
	logic ph_q;
	logic last_burst;
	int rd_cnt = 0;
	int wr_cnt = 0;
	function automatic logic [31:0] word(input logic [31:0] a);
		return mem.exists(a[31:2]) ? mem[a[31:2]] : ({a[31:2], 2'b00} ^ 32'h5a5a0000);
	endfunction
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ready_o <= 1'b0;
			wr_ready_o <= 1'b0;
			beat_valid_o <= 1'b0;
			beat_data_o <= 32'h0;
			left_q <= 3'h0;
			ph_q <= 1'b0;
		end else begin
			ph_q <= ~ph_q;
			rd_ready_o <= (~slow_i | ph_q) & (left_q == 3'h0);
			wr_ready_o <= ~slow_i | ph_q;
			beat_valid_o <= 1'b0;
			beat_data_o <= ~beat_data_o;
			if (rd_valid_i && rd_ready_o) begin
				base_q <= rd_addr_i;
				wofs_q <= 2'h0;
				left_q <= rd_burst_i ? 3'h4 : 3'h1;
				last_burst <= rd_burst_i;
				rd_cnt <= rd_cnt + 1;
			end else if (left_q != 3'h0 && (~slow_i | ph_q)) begin
				beat_valid_o <= 1'b1;
				beat_data_o <= word({base_q[31:4], base_q[3:2] + wofs_q, 2'b00});
				wofs_q <= wofs_q + 2'h1;
				left_q <= left_q - 3'h1;
			end
			if (wr_valid_i && wr_ready_o) begin
				tmp = word(wr_addr_i);
				for (int b = 0; b < 4; b++) begin
					if (wr_be_i[b]) tmp[8*b+:8] = wr_data_i[8*b+:8];
				end
				mem[wr_addr_i[31:2]] = tmp;
				wr_cnt <= wr_cnt + 1;
			end
		end
	end
endmodule

//--- tb/test_ctr_cache_ctrl.sv
// Purpose: self-checking bench for the cache tag and replacement block
// Assumes: bus model answers refills and stores
// Notes: arrays are seeded through maintenance commands first
`timescale 1ns/1ps
module test_ctr_cache_ctrl
	import ctr_pkg::*;
;
	localparam logic [31:0] LA = 32'h00010048;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b0;
	logic slow = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic req_valid_i = 1'b0;
	logic req_cached_i = 1'b0;
	logic [1:0] req_kind_i = 2'h0;
	logic [3:0] req_be_i = 4'h0;
	logic [31:0] req_va_i = 32'h0;
	logic [31:0] req_pa_i = 32'h0;
	logic [31:0] req_wdata_i = 32'h0;
	logic [31:0] prdata_o, rsp_data_o, rd_addr_o, beat_data_i, wr_addr_o, wr_data_o, q, mrg;
	logic pready_o, pslverr_o, req_ready_o, rsp_valid_o, rd_valid_o, rd_ready_i, rd_burst_o;
	logic beat_valid_i, wr_valid_o, wr_ready_i, err;
	logic [3:0] wr_be_o;
	int fails = 0;
	int check_count = 0;
	ctr_cache_ctrl ctr_cache_ctrl_i (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .req_valid_i, .req_ready_o, .req_kind_i,
		.req_va_i, .req_pa_i, .req_cached_i, .req_be_i, .req_wdata_i, .rsp_valid_o, .rsp_data_o,
		.rd_valid_o, .rd_ready_i, .rd_addr_o, .rd_burst_o, .beat_valid_i, .beat_data_i,
		.wr_valid_o, .wr_ready_i, .wr_addr_o, .wr_be_o, .wr_data_o);
	ctr_bus_model ctr_bus_model_i (.clk_i(mclk_i), .rst_i(rst_i), .slow_i(slow),
		.rd_valid_i(rd_valid_o), .rd_ready_o(rd_ready_i), .rd_addr_i(rd_addr_o),
		.rd_burst_i(rd_burst_o), .beat_valid_o(beat_valid_i), .beat_data_o(beat_data_i),
		.wr_valid_i(wr_valid_o), .wr_ready_o(wr_ready_i), .wr_addr_i(wr_addr_o),
		.wr_be_i(wr_be_o), .wr_data_i(wr_data_o));
	always #10 mclk_i = ~mclk_i;
	function automatic logic [31:0] mw(input logic [31:0] a);
		return {a[31:2], 2'b00} ^ 32'h5a5a0000;
	endfunction
	function automatic logic [31:0] ra(input int t);
		return 32'h00020080 + 32'(t) * 32'h400;
	endfunction
	function automatic logic [31:0] rc();
		return 32'(ctr_bus_model_i.rd_cnt);
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_hi(ref logic s);
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		// look mid-cycle at the value that stands at the next rising edge
		while (!ok && n < 500) begin
			@(negedge mclk_i);
			ok = s === 1'b1;
			@(posedge mclk_i);
			n++;
		end
		if (!ok) begin
			chk("handshake", 32'h0, 32'h1);
			wrap_up();
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		wait_hi(pready_o);
		q = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic cmd(input logic [1:0] op, input logic [1:0] w, input logic [5:0] s);
		apb(1'b1, OFS_CMD, {18'h0, s, 2'h0, w, 2'h0, op});
	endtask
	task automatic acc(input logic [1:0] k, input logic [31:0] va, input logic c,
		input logic [3:0] be, input logic [31:0] wd);
		@(posedge mclk_i);
		req_valid_i <= 1'b1;
		req_kind_i <= k;
		req_va_i <= va;
		req_pa_i <= {3'h0, va[28:0]};
		req_cached_i <= c;
		req_be_i <= be;
		req_wdata_i <= wd;
		wait_hi(req_ready_o);
		req_valid_i <= 1'b0;
		wait_hi(rsp_valid_o);
		q = rsp_data_o;
	endtask
	task automatic vict(input int t, input logic [2:0] e);
		acc(K_LOAD, ra(t), 1'b1, 4'h0, 32'h0);
		chk("victim data", q, mw(ra(t)));
		apb(1'b0, OFS_STAT, 32'h0);
		chk("victim", {29'h0, q[ST_VWAY_LSB+:2], q[ST_VFOUND_BIT]}, {29'h0, e});
	endtask
	task automatic t_regs();
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", {31'h0, q[CTRL_EN_BIT]}, {31'h0, CTRL_EN_RST});
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", {err, q[30:0]}, 32'h80000000);
		apb(1'b1, OFS_TAG, 32'h0);
		for (int s = 0; s < NSETS; s++) begin
			for (int w = 0; w < NWAYS; w++) cmd(OP_STORE, w[1:0], s[5:0]);
		end
	endtask
	task automatic t_miss_hit();
		logic [31:0] a;
		logic [31:0] r;
		for (int i = 0; i < 2; i++) begin
			a = LA + 32'(i) * 32'h10;
			r = rc();
			acc(i ? K_LOAD : K_FETCH, a, 1'b1, 4'h0, 32'h0);
			chk("critical word", q, mw(a));
			chk("miss address", rd_addr_o, {a[31:2], 2'b00});
			chk("burst", {31'h0, ctr_bus_model_i.last_burst}, 32'h1);
			for (int w = 0; w < 4; w++) begin
				acc(i ? K_LOAD : K_FETCH, {a[31:4], w[1:0], 2'b00}, 1'b1, 4'h0, 32'h0);
				chk("line word", q, mw({a[31:4], w[1:0], 2'b00}));
			end
			chk("reads", rc(), r + 1);
		end
	endtask
	task automatic t_store();
		logic [31:0] r;
		int w0;
		cmd(OP_LOCK, 2'h0, 6'h4);
		w0 = ctr_bus_model_i.wr_cnt;
		r = rc();
		mrg = mw(LA);
		mrg[15:8] = 8'hab;
		acc(K_STORE, LA, 1'b1, 4'h2, 32'h0000ab00);
		acc(K_SYNC, LA, 1'b1, 4'h0, 32'h0);
		chk("written", 32'(ctr_bus_model_i.wr_cnt), 32'(w0 + 1));
		acc(K_LOAD, LA, 1'b1, 4'h0, 32'h0);
		chk("merged", q, mrg);
		chk("hit reads", rc(), r);
		acc(K_STORE, LA + 32'h400, 1'b1, 4'hf, 32'h12345678);
		acc(K_SYNC, LA, 1'b1, 4'h0, 32'h0);
		acc(K_LOAD, LA + 32'h400, 1'b1, 4'h0, 32'h0);
		chk("miss store data", q, 32'h12345678);
		chk("miss store reads", rc(), r + 1);
	endtask
	task automatic t_unc();
		logic [31:0] r;
		r = rc();
		acc(K_LOAD, LA, 1'b0, 4'h0, 32'h0);
		chk("unc data", q, mrg);
		chk("unc single", {31'h0, ctr_bus_model_i.last_burst}, 32'h0);
		acc(K_STORE, LA, 1'b0, 4'hf, 32'h0bad0001);
		acc(K_SYNC, LA, 1'b1, 4'h0, 32'h0);
		acc(K_LOAD, LA, 1'b1, 4'h0, 32'h0);
		chk("unc kept", q, mrg);
		chk("unc reads", rc(), r + 1);
		acc(K_LOAD, {SEG_UNC, LA[28:0]}, 1'b1, 4'h0, 32'h0);
		chk("seg data", q, 32'h0bad0001);
		chk("seg reads", rc(), r + 2);
		apb(1'b1, OFS_CTRL, 32'h0);
		acc(K_LOAD, LA, 1'b1, 4'h0, 32'h0);
		chk("off data", q, 32'h0bad0001);
		chk("off reads", rc(), r + 3);
		apb(1'b1, OFS_CTRL, 32'h1);
	endtask
	task automatic t_repl();
		logic [31:0] r;
		for (int t = 0; t < 4; t++) vict(t, {t[1:0], 1'b1});
		cmd(OP_LOCK, 2'h0, 6'h8);
		vict(4, 3'b011);
		vict(5, 3'b101);
		for (int w = 1; w < 4; w++) cmd(OP_LOCK, w[1:0], 6'h8);
		r = rc();
		acc(K_LOAD, ra(6), 1'b1, 4'h0, 32'h0);
		chk("all locked data", q, mw(ra(6)));
		apb(1'b0, OFS_STAT, 32'h0);
		chk("none found", {31'h0, q[ST_VFOUND_BIT]}, 32'h0);
		acc(K_LOAD, ra(6), 1'b1, 4'h0, 32'h0);
		acc(K_LOAD, ra(0), 1'b1, 4'h0, 32'h0);
		chk("no fill", rc(), r + 2);
		cmd(OP_UNLOCK, 2'h1, 6'h8);
		vict(7, 3'b011);
		cmd(OP_INV, 2'h0, 6'h8);
		vict(0, 3'b001);
	endtask
	task automatic t_sync();
		int w0;
		slow <= 1'b1;
		w0 = ctr_bus_model_i.wr_cnt;
		acc(K_STORE, LA + 32'h4, 1'b1, 4'hf, 32'h11112222);
		acc(K_STORE, LA + 32'h8, 1'b1, 4'h3, 32'h33334444);
		acc(K_SYNC, LA, 1'b1, 4'h0, 32'h0);
		chk("drained", 32'(ctr_bus_model_i.wr_cnt), 32'(w0 + 2));
		apb(1'b0, OFS_STAT, 32'h0);
		chk("buffer empty", {31'h0, q[ST_WBUF_BIT]}, 32'h0);
		acc(K_LOAD, LA + 32'h800, 1'b1, 4'h0, 32'h0);
		chk("slow refill", q, mw(LA + 32'h800));
		slow <= 1'b0;
	endtask
	initial begin
		rst_i = 1'b1;
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_regs();
		t_miss_hit();
		t_store();
		t_unc();
		t_repl();
		t_sync();
		wrap_up();
	end
endmodule
